/* File: include/adcs_pkg.sv */
package adcs_pkg;
   localparam int ADCS_ADDR_W = 5;
   localparam int ADCS_DATA_W = 8;
   // register offsets
   localparam logic [4:0] ADCS_OFS_CTRL = 5'h00;
   localparam logic [4:0] ADCS_OFS_ACCUM = 5'h01;
   localparam logic [4:0] ADCS_OFS_CLKDIV = 5'h02;
   localparam logic [4:0] ADCS_OFS_WINMODE = 5'h04;
   localparam logic [4:0] ADCS_OFS_SAMPLE_LENGTH = 5'h05;
   localparam logic [4:0] ADCS_OFS_INSEL = 5'h06;
   localparam logic [4:0] ADCS_OFS_CMD = 5'h08;
   localparam logic [4:0] ADCS_OFS_EVENT_INPUT_CTRL = 5'h09;
   localparam logic [4:0] ADCS_OFS_IRQEN = 5'h0a;
   localparam logic [4:0] ADCS_OFS_IRQFLAG = 5'h0b;
   localparam logic [4:0] ADCS_OFS_DBG = 5'h0c;
   localparam logic [4:0] ADCS_OFS_TEMP = 5'h0d;
   localparam logic [4:0] ADCS_OFS_RES = 5'h10;
   localparam logic [4:0] ADCS_OFS_WINDOW_LOW_THRESHOLD = 5'h12;
   localparam logic [4:0] ADCS_OFS_WINDOW_HIGH_THRESHOLD = 5'h14;
   localparam logic [4:0] ADCS_OFS_CLOCK_DUTY_CALIBRATION = 5'h16;
   localparam logic [4:0] ADCS_OFS_HIGH = 5'h01;
   // bit positions
   localparam int ADCS_BIT_ENABLE = 0;
   localparam int ADCS_BIT_CONTINUOUS_CONVERSION = 1;
   localparam int ADCS_BIT_START = 0;
   localparam int ADCS_BIT_EVSTART = 0;
   localparam int ADCS_BIT_RESULT_READY = 0;
   localparam int ADCS_BIT_WINDOW_COMPARE_FLAG = 1;
   localparam int ADCS_BIT_RUN_IN_DEBUG_HALT = 0;
   localparam int ADCS_BIT_DUTY = 0;
   // reset values
   localparam logic ADCS_DUTY_RST = 1'b1;
   // timing in converter clock cycles
   localparam logic [5:0] ADCS_SAMP_BASE = 6'h02;
   localparam logic [5:0] ADCS_CONV_CYCLES = 6'h0a;
   // window modes and accumulation limit
   localparam logic [2:0] ADCS_WIN_NONE = 3'h0;
   localparam logic [2:0] ADCS_WIN_BELOW = 3'h1;
   localparam logic [2:0] ADCS_WIN_ABOVE = 3'h2;
   localparam logic [2:0] ADCS_WIN_INSIDE = 3'h3;
   localparam logic [2:0] ADCS_WIN_OUTSIDE = 3'h4;
   localparam logic [2:0] ADCS_ACC_MAX = 3'h6;
   // input selector codes
   localparam logic [4:0] ADCS_IN_PIN_LAST = 5'h07;
   localparam logic [4:0] ADCS_IN_PIN10 = 5'h0a;
   localparam logic [4:0] ADCS_IN_PIN11 = 5'h0b;
   localparam logic [4:0] ADCS_IN_INTERNAL_REFERENCE_INPUT = 5'h1d;
   localparam logic [4:0] ADCS_IN_GND = 5'h1f;
   // raw result limits
   localparam logic [9:0] ADCS_RAW_MAX = 10'h3ff;
   localparam logic [9:0] ADCS_RAW_MIN = 10'h000;
   typedef enum logic [2:0] {
      ADCS_IDLE = 3'b001,
      ADCS_SAMPLE = 3'b010,
      ADCS_CONVERT = 3'b100
   } adcs_state_e;
endpackage

/* File: rtl/adcs_clkgen.sv */
`timescale 1ns/1ps
module adcs_clkgen (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [2:0] i_div_code,
   input wire logic i_duty_quarter,
   input wire logic i_run,
   output logic o_adc_clk,
   output logic o_tick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic clk;
      logic tick;
   } adcs_clk_s;

   adcs_clk_s r, n;
   logic [8:0] div;
   logic [7:0] last;
   logic [7:0] high_len;

   always_comb begin
      div = 9'h002 << i_div_code; // see RULE23
      last = 8'(div - 9'h001);
      // quarter high time, but never shorter than one system clock
      high_len = i_duty_quarter ? 8'(div >> 2) : 8'(div >> 1); // see RULE19
      if (high_len == 8'h00) begin
         high_len = 8'h01;
      end
      n = r;
      n.tick = i_run && (r.cnt == last);
      if (!i_run || r.cnt == last) begin
         n.cnt = 8'h00;
      end else begin
         n.cnt = r.cnt + 8'h01;
      end
      n.clk = i_run && (n.cnt < high_len);
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign o_adc_clk = r.clk;
   assign o_tick = r.tick;
endmodule

/* File: rtl/adcs_regs.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: sample length field extends sampling phase
// RULE2: zero length samples two converter cycles
// RULE3: selector maps pins, reference, ground codes
// RULE4: selector change applies after running conversion
// RULE5: start bit begins single or continuous run
// RULE6: start bit reads one while busy
// RULE7: enabled event input starts a conversion
// RULE8: interrupt enable bits gate each flag
// RULE9: window compared at each conversion end
// RULE10: window flag cleared by one or read
// RULE11: result ready set on each completion
// RULE12: result ready cleared by one or read
// RULE13: debug halt freezes converter unless allowed
// RULE14: one shared temporary byte for wide access
// RULE15: raw result clamps at full and zero
// RULE16: high byte sits at base plus one
// RULE17: result and thresholds unsigned magnitude
// RULE18: window checks accumulated sum, not samples
// RULE19: duty bit selects half or quarter high
// RULE20: window mode selects below/above/inside/outside
// RULE21: continuous mode restarts right after completion
// RULE22: accumulation sums two-power consecutive samples
// RULE23: converter clock divides by two to 256
// RULE24: low byte read latches high byte
module adcs_regs (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [4:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_event_start,
   input wire logic i_debug_halt,
   input wire logic [9:0] i_conv_data,
   input wire logic i_over_ref,
   input wire logic i_under_gnd,
   output logic [4:0] o_mux_sel,
   output logic o_sampling,
   output logic o_adc_clk,
   output logic o_irq
);
   typedef struct packed {
      adcs_pkg::adcs_state_e state;
      logic enable;
      logic continuous_conversion;
      logic [2:0] accum;
      logic [2:0] clkdiv;
      logic [2:0] winmode;
      logic [4:0] sample_length;
      logic [4:0] insel;
      logic [4:0] mux_act;
      logic evstart;
      logic [1:0] irqen;
      logic [1:0] flags;
      logic run_in_debug_halt;
      logic [7:0] temp;
      logic [15:0] res;
      logic [15:0] window_low_threshold;
      logic [15:0] window_high_threshold;
      logic duty;
      logic [15:0] acc;
      logic [6:0] smp_cnt;
      logic [5:0] phase;
      logic [7:0] rdata;
      logic irq;
      logic sampling;
   } adcs_regs_s;

   adcs_regs_s r, n;
   logic tick;
   logic halted;
   logic start_req;
   logic done_evt;
   logic [1:0] clr;
   logic [1:0] set;
   logic [9:0] smp;
   logic [15:0] acc_new;
   logic [6:0] target;
   logic [2:0] acc_eff;
   logic [5:0] samp_last;

   // reserved codes fall back to ground rather than an undefined input
   function automatic logic [4:0] insel_map(input logic [4:0] code);
      if (code <= adcs_pkg::ADCS_IN_PIN_LAST || code == adcs_pkg::ADCS_IN_PIN10 ||
          code == adcs_pkg::ADCS_IN_PIN11 || code == adcs_pkg::ADCS_IN_INTERNAL_REFERENCE_INPUT) begin
         return code; // see RULE3
      end
      return adcs_pkg::ADCS_IN_GND;
   endfunction

   function automatic logic win_hit(input logic [15:0] v, input logic [2:0] mode,
                                    input logic [15:0] lt, input logic [15:0] ht);
      case (mode) // see RULE20
         adcs_pkg::ADCS_WIN_BELOW: return v < lt;
         adcs_pkg::ADCS_WIN_ABOVE: return v > ht;
         adcs_pkg::ADCS_WIN_INSIDE: return (v > lt) && (v < ht);
         adcs_pkg::ADCS_WIN_OUTSIDE: return (v < lt) || (v > ht);
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic is_addr(input logic [4:0] a, input logic [4:0] ofs);
      return a == ofs;
   endfunction

   adcs_clkgen u_clkgen (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_div_code(r.clkdiv),
      .i_duty_quarter(r.duty),
      .i_run((r.state != adcs_pkg::ADCS_IDLE) && !halted),
      .o_adc_clk(o_adc_clk),
      .o_tick(tick)
   );

   always_comb begin
      n = r;
      n.rdata = 8'h00;
      clr = 2'b00;
      set = 2'b00;
      done_evt = 1'b0;
      halted = i_debug_halt && !r.run_in_debug_halt; // see RULE13
      smp = i_conv_data;
      if (i_over_ref) begin
         smp = adcs_pkg::ADCS_RAW_MAX; // see RULE15
      end else if (i_under_gnd) begin
         smp = adcs_pkg::ADCS_RAW_MIN; // see RULE15
      end
      acc_new = r.acc + {6'h00, smp}; // see RULE17
      acc_eff = (r.accum > adcs_pkg::ADCS_ACC_MAX) ? adcs_pkg::ADCS_ACC_MAX : r.accum;
      target = 7'h01 << acc_eff; // see RULE22
      samp_last = adcs_pkg::ADCS_SAMP_BASE + {1'b0, r.sample_length} - 6'h01; // see RULE1

      // register reads, data stand in the next cycle only
      if (i_rd) begin
         case (i_addr)
            adcs_pkg::ADCS_OFS_CTRL: n.rdata = {6'h00, r.continuous_conversion, r.enable};
            adcs_pkg::ADCS_OFS_ACCUM: n.rdata = {5'h00, r.accum};
            adcs_pkg::ADCS_OFS_CLKDIV: n.rdata = {5'h00, r.clkdiv};
            adcs_pkg::ADCS_OFS_WINMODE: n.rdata = {5'h00, r.winmode};
            adcs_pkg::ADCS_OFS_SAMPLE_LENGTH: n.rdata = {3'h0, r.sample_length};
            adcs_pkg::ADCS_OFS_INSEL: n.rdata = {3'h0, r.insel};
            adcs_pkg::ADCS_OFS_CMD: begin
               n.rdata = {7'h00, r.state != adcs_pkg::ADCS_IDLE}; // see RULE6
            end
            adcs_pkg::ADCS_OFS_EVENT_INPUT_CTRL: n.rdata = {7'h00, r.evstart};
            adcs_pkg::ADCS_OFS_IRQEN: n.rdata = {6'h00, r.irqen};
            adcs_pkg::ADCS_OFS_IRQFLAG: n.rdata = {6'h00, r.flags};
            adcs_pkg::ADCS_OFS_DBG: n.rdata = {7'h00, r.run_in_debug_halt};
            adcs_pkg::ADCS_OFS_TEMP: n.rdata = r.temp; // see RULE14
            adcs_pkg::ADCS_OFS_RES: begin
               n.rdata = r.res[7:0];
               n.temp = r.res[15:8]; // see RULE24
               clr = 2'b11; // see RULE10, RULE12
            end
            adcs_pkg::ADCS_OFS_WINDOW_LOW_THRESHOLD: begin
               n.rdata = r.window_low_threshold[7:0];
               n.temp = r.window_low_threshold[15:8]; // see RULE24
            end
            adcs_pkg::ADCS_OFS_WINDOW_HIGH_THRESHOLD: begin
               n.rdata = r.window_high_threshold[7:0];
               n.temp = r.window_high_threshold[15:8]; // see RULE24
            end
            adcs_pkg::ADCS_OFS_RES + adcs_pkg::ADCS_OFS_HIGH,
            adcs_pkg::ADCS_OFS_WINDOW_LOW_THRESHOLD + adcs_pkg::ADCS_OFS_HIGH,
            adcs_pkg::ADCS_OFS_WINDOW_HIGH_THRESHOLD + adcs_pkg::ADCS_OFS_HIGH: begin
               n.rdata = r.temp; // see RULE16
            end
            adcs_pkg::ADCS_OFS_CLOCK_DUTY_CALIBRATION: n.rdata = {7'h00, r.duty};
            default: n.rdata = 8'h00;
         endcase
      end

      // register writes; wide registers commit on the high byte
      if (i_wr) begin
         case (i_addr)
            adcs_pkg::ADCS_OFS_CTRL: begin
               n.enable = i_wdata[adcs_pkg::ADCS_BIT_ENABLE];
               n.continuous_conversion = i_wdata[adcs_pkg::ADCS_BIT_CONTINUOUS_CONVERSION];
            end
            adcs_pkg::ADCS_OFS_ACCUM: n.accum = i_wdata[2:0];
            adcs_pkg::ADCS_OFS_CLKDIV: n.clkdiv = i_wdata[2:0];
            adcs_pkg::ADCS_OFS_WINMODE: n.winmode = i_wdata[2:0];
            adcs_pkg::ADCS_OFS_SAMPLE_LENGTH: n.sample_length = i_wdata[4:0];
            adcs_pkg::ADCS_OFS_INSEL: n.insel = i_wdata[4:0];
            adcs_pkg::ADCS_OFS_EVENT_INPUT_CTRL: n.evstart = i_wdata[adcs_pkg::ADCS_BIT_EVSTART];
            adcs_pkg::ADCS_OFS_IRQEN: n.irqen = i_wdata[1:0];
            adcs_pkg::ADCS_OFS_IRQFLAG: clr = i_wdata[1:0]; // see RULE10, RULE12
            adcs_pkg::ADCS_OFS_DBG: n.run_in_debug_halt = i_wdata[adcs_pkg::ADCS_BIT_RUN_IN_DEBUG_HALT];
            adcs_pkg::ADCS_OFS_TEMP,
            adcs_pkg::ADCS_OFS_WINDOW_LOW_THRESHOLD,
            adcs_pkg::ADCS_OFS_WINDOW_HIGH_THRESHOLD: n.temp = i_wdata; // see RULE14
            adcs_pkg::ADCS_OFS_WINDOW_LOW_THRESHOLD + adcs_pkg::ADCS_OFS_HIGH: begin
               n.window_low_threshold = {i_wdata, r.temp}; // see RULE16
            end
            adcs_pkg::ADCS_OFS_WINDOW_HIGH_THRESHOLD + adcs_pkg::ADCS_OFS_HIGH: begin
               n.window_high_threshold = {i_wdata, r.temp}; // see RULE16
            end
            adcs_pkg::ADCS_OFS_CLOCK_DUTY_CALIBRATION: n.duty = i_wdata[adcs_pkg::ADCS_BIT_DUTY];
            default: n.temp = n.temp;
         endcase
      end

      start_req = (i_wr && is_addr(i_addr, adcs_pkg::ADCS_OFS_CMD) &&
                   i_wdata[adcs_pkg::ADCS_BIT_START]) || // see RULE5
                  (r.evstart && i_event_start && !halted); // see RULE7, RULE13

      // conversion engine; sample and convert phases advance only on converter clock ticks
      case (r.state)
         adcs_pkg::ADCS_IDLE: begin
            if (r.enable && start_req) begin
               n.state = adcs_pkg::ADCS_SAMPLE;
               n.mux_act = insel_map(r.insel); // see RULE4
               n.phase = 6'h00;
               n.acc = 16'h0000;
               n.smp_cnt = 7'h00;
               n.sampling = 1'b1;
            end
         end
         adcs_pkg::ADCS_SAMPLE: begin
            if (tick) begin
               if (r.phase == samp_last) begin // see RULE1, RULE2
                  n.state = adcs_pkg::ADCS_CONVERT;
                  n.phase = 6'h00;
                  n.sampling = 1'b0;
               end else begin
                  n.phase = r.phase + 6'h01;
               end
            end
         end
         adcs_pkg::ADCS_CONVERT: begin
            if (tick) begin
               if (r.phase != adcs_pkg::ADCS_CONV_CYCLES - 6'h01) begin
                  n.phase = r.phase + 6'h01;
               end else if (r.smp_cnt != target - 7'h01) begin
                  n.acc = acc_new; // see RULE22
                  n.smp_cnt = r.smp_cnt + 7'h01;
                  n.phase = 6'h00;
                  n.state = adcs_pkg::ADCS_SAMPLE;
                  n.sampling = 1'b1;
               end else begin
                  done_evt = 1'b1;
                  n.res = acc_new;
                  set[adcs_pkg::ADCS_BIT_RESULT_READY] = 1'b1; // see RULE11
                  // see RULE9, RULE18
                  set[adcs_pkg::ADCS_BIT_WINDOW_COMPARE_FLAG] = win_hit(acc_new, r.winmode,
                                                          r.window_low_threshold, r.window_high_threshold);
                  if (r.continuous_conversion) begin
                     n.state = adcs_pkg::ADCS_SAMPLE; // see RULE21
                     n.mux_act = insel_map(r.insel); // see RULE4
                     n.phase = 6'h00;
                     n.acc = 16'h0000;
                     n.smp_cnt = 7'h00;
                     n.sampling = 1'b1;
                  end else begin
                     n.state = adcs_pkg::ADCS_IDLE; // see RULE6
                  end
               end
            end
         end
         default: n.state = adcs_pkg::ADCS_IDLE;
      endcase

      // disabling the converter abandons a conversion without a result
      if (!n.enable) begin
         n.state = adcs_pkg::ADCS_IDLE;
         n.sampling = 1'b0;
      end

      // a completion in the clearing cycle keeps its flag
      n.flags = (r.flags & ~clr) | set;
      n.irq = |(n.flags & n.irqen); // see RULE8
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= '0;
         r.state <= adcs_pkg::ADCS_IDLE;
         r.duty <= adcs_pkg::ADCS_DUTY_RST; // see RULE19
      end else begin
         r <= n;
      end
   end

   assign o_rdata = r.rdata;
   assign o_mux_sel = r.mux_act;
   assign o_sampling = r.sampling;
   assign o_irq = r.irq;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   start_cmd_a: assert property ( // see RULE5
      r.state == adcs_pkg::ADCS_IDLE && r.enable && i_wr &&
      i_addr == adcs_pkg::ADCS_OFS_CMD && i_wdata[adcs_pkg::ADCS_BIT_START]
      |=> r.state == adcs_pkg::ADCS_SAMPLE && o_sampling)
      else $error("start bit write did not begin sampling");

   busy_read_a: assert property ( // see RULE6
      i_rd && i_addr == adcs_pkg::ADCS_OFS_CMD
      |=> o_rdata[0] == ($past(r.state) != adcs_pkg::ADCS_IDLE))
      else $error("start bit read does not show busy state");

   event_start_a: assert property ( // see RULE7
      r.state == adcs_pkg::ADCS_IDLE && r.enable && r.evstart &&
      i_event_start && !halted |=> r.state == adcs_pkg::ADCS_SAMPLE)
      else $error("enabled event did not start a conversion");

   halt_ignore_a: assert property ( // see RULE13
      r.state == adcs_pkg::ADCS_IDLE && halted && !i_wr
      |=> r.state == adcs_pkg::ADCS_IDLE)
      else $error("converter started while halted in debug");

   irq_gate_a: assert property ( // see RULE8
      ##1 o_irq == |(r.flags & r.irqen))
      else $error("interrupt output disagrees with gated flags");

   read_clear_a: assert property ( // see RULE12
      i_rd && i_addr == adcs_pkg::ADCS_OFS_RES && !done_evt |=> r.flags == 2'b00)
      else $error("result read did not clear the flags");

   zero_keep_a: assert property ( // see RULE10
      i_wr && i_addr == adcs_pkg::ADCS_OFS_IRQFLAG && i_wdata[1:0] == 2'b00
      |=> r.flags == ($past(r.flags) | $past(set)))
      else $error("writing zero changed a flag");

   mux_hold_a: assert property ( // see RULE4
      r.state == adcs_pkg::ADCS_SAMPLE |=> o_mux_sel == $past(o_mux_sel))
      else $error("input selection changed mid conversion");

   samp_end_a: assert property ( // see RULE1
      r.state == adcs_pkg::ADCS_SAMPLE && tick && r.enable && r.phase == samp_last
      |=> r.state == adcs_pkg::ADCS_CONVERT && !o_sampling)
      else $error("sampling phase length wrong");

   clamp_top_a: assert property ( // see RULE15
      done_evt && i_over_ref && r.accum == 3'h0 |=> r.res == 16'h03ff)
      else $error("over-range sample not clamped to full scale");

   cover_single_c: cover property (r.state == adcs_pkg::ADCS_IDLE ##1
                                   r.state == adcs_pkg::ADCS_SAMPLE);
   cover_done_c: cover property (done_evt && !r.continuous_conversion);
   cover_free_c: cover property (done_evt && r.continuous_conversion);
   cover_window_compare_flag_c: cover property (done_evt && set[adcs_pkg::ADCS_BIT_WINDOW_COMPARE_FLAG]);
endmodule

/* File: verification/tb_adc_sequencer_regs.sv */
`timescale 1ns/1ps
module tb_adc_sequencer_regs;
   logic i_clk_sys = 1'b0;
   logic i_rst_n = 1'b0;
   logic [4:0] i_addr = 5'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_event_start = 1'b0;
   logic i_debug_halt = 1'b0;
   logic [9:0] i_conv_data = 10'h000;
   logic i_over_ref = 1'b0;
   logic i_under_gnd = 1'b0;
   logic [7:0] o_rdata;
   logic [4:0] o_mux_sel;
   logic o_sampling;
   logic o_adc_clk;
   logic o_irq;
   int fails = 0;
   int checks = 0;
   int cycles = 0;
   int samp_cnt = 0;
   int samp_len = 0;
   int d0 = 0;
   logic rd_d = 1'b0;
   logic [31:0] seed = 32'h00000035;
   logic [15:0] exp_q[$];
   string nm_q[$];

   always #25 i_clk_sys = ~i_clk_sys;

   adcs_regs dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_event_start(i_event_start),
      .i_debug_halt(i_debug_halt), .i_conv_data(i_conv_data), .i_over_ref(i_over_ref),
      .i_under_gnd(i_under_gnd), .o_mux_sel(o_mux_sel), .o_sampling(o_sampling),
      .o_adc_clk(o_adc_clk), .o_irq(o_irq));

   task automatic give_verdict();
      if (fails == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   function automatic logic win(input logic [2:0] m, input logic [15:0] r, input logic [15:0] lt,
                                input logic [15:0] ht);
      case (m)
         3'h1: win = r < lt;
         3'h2: win = r > ht;
         3'h3: win = (r > lt) && (r < ht);
         3'h4: win = (r < lt) || (r > ht);
         default: win = 1'b0;
      endcase
   endfunction

   // a hang anywhere ends the run through the same report
   always @(posedge i_clk_sys) begin
      rd_d <= i_rd;
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fails = fails + 1;
         give_verdict();
      end
   end

   // read data stands only in the cycle after the strobe, so look mid-cycle
   always @(negedge i_clk_sys) begin
      if (o_sampling === 1'b1) samp_cnt = samp_cnt + 1;
      if (rd_d === 1'b1) check(nm_q.pop_front(), {8'h00, o_rdata}, exp_q.pop_front());
   end

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      @(posedge i_clk_sys);
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
      exp_q.push_back({8'h00, e});
      nm_q.push_back(nm);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      @(posedge i_clk_sys);
   endtask

   task automatic wr16(input logic [4:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a + adcs_pkg::ADCS_OFS_HIGH, v[15:8]);
   endtask

   task automatic rres(input logic [15:0] v);
      rd(adcs_pkg::ADCS_OFS_RES, v[7:0], "res_lo");
      rd(adcs_pkg::ADCS_OFS_RES + adcs_pkg::ADCS_OFS_HIGH, v[15:8], "res_hi");
      rd(adcs_pkg::ADCS_OFS_IRQFLAG, 8'h00, "flags_rd_clr");
   endtask

   task automatic wait_on(input logic irq, input logic lvl);
      int n;
      n = 0;
      while (((irq ? o_irq : o_sampling) !== lvl) && n < 5000) begin
         @(posedge i_clk_sys);
         n++;
      end
      if (n == 5000) check("wait", 16'h0000, 16'h0001);
   endtask

   task automatic pulse();
      i_event_start <= 1'b1;
      @(posedge i_clk_sys);
      i_event_start <= 1'b0;
   endtask

   task automatic convert(input logic [9:0] d, input logic ev, input logic [4:0] msel,
                          input logic [4:0] chg);
      int s0;
      s0 = samp_cnt;
      i_conv_data <= d;
      if (ev) begin
         pulse();
      end else begin
         wr(adcs_pkg::ADCS_OFS_CMD, 8'h01);
      end
      wait_on(1'b0, 1'b1);
      check("mux_sel", {11'h000, o_mux_sel}, {11'h000, msel});
      rd(adcs_pkg::ADCS_OFS_CMD, 8'h01, "busy");
      wr(adcs_pkg::ADCS_OFS_INSEL, {3'h0, chg});
      wait_on(1'b0, 1'b0);
      wait_on(1'b1, 1'b1);
      check("mux_held", {11'h000, o_mux_sel}, {11'h000, msel});
      rd(adcs_pkg::ADCS_OFS_CMD, 8'h00, "idle");
      samp_len = samp_cnt - s0;
   endtask

   // first and last high phases are cut short, so time one in mid-conversion
   task automatic duty(input logic q, input logic [15:0] hi);
      int n;
      n = 0;
      wr(adcs_pkg::ADCS_OFS_CLOCK_DUTY_CALIBRATION, {7'h00, q});
      wr(adcs_pkg::ADCS_OFS_CMD, 8'h01);
      wait_on(1'b0, 1'b0);
      while (o_adc_clk === 1'b1) @(posedge i_clk_sys);
      while (o_adc_clk !== 1'b1) @(posedge i_clk_sys);
      while (o_adc_clk === 1'b1) begin
         @(posedge i_clk_sys);
         n++;
      end
      check("duty_high", 16'(n), hi);
      wait_on(1'b1, 1'b1);
      rres(16'h0001);
   endtask

   initial begin
      int i;
      int m;
      int k;
      logic [7:0] r;
      logic [15:0] res;
      logic [4:0] rwo [7];
      logic [7:0] rwm [7];
      logic [4:0] sc [4];
      logic [4:0] sm [4];
      logic [9:0] dv [5];
      rwo = '{5'h05, 5'h06, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h16};
      rwm = '{8'h1f, 8'h1f, 8'h01, 8'h03, 8'h01, 8'hff, 8'h01};
      sc = '{5'h08, 5'h0a, 5'h1d, 5'h1c};
      sm = '{5'h1f, 5'h0a, 5'h1d, 5'h1f};
      dv = '{10'h080, 10'h100, 10'h180, 10'h200, 10'h280};
      repeat (16) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      @(posedge i_clk_sys);
      for (i = 0; i < 32; i++) begin
         rd(i[4:0], (i == 32'h16) ? 8'h01 : 8'h00, "reset_value");
      end
      for (i = 0; i < 7; i++) begin
         seed = xs(seed);
         wr(rwo[i], seed[7:0]);
         rd(rwo[i], seed[7:0] & rwm[i], "rw_field");
      end
      wr(adcs_pkg::ADCS_OFS_RES, 8'hff);
      rd(adcs_pkg::ADCS_OFS_RES, 8'h00, "res_read_only");
      wr16(adcs_pkg::ADCS_OFS_WINDOW_LOW_THRESHOLD, 16'h0100);
      wr16(adcs_pkg::ADCS_OFS_WINDOW_HIGH_THRESHOLD, 16'h0200);
      rd(adcs_pkg::ADCS_OFS_WINDOW_HIGH_THRESHOLD, 8'h00, "window_high_threshold_lo");
      rd(adcs_pkg::ADCS_OFS_TEMP, 8'h02, "temp_copy");
      rd(adcs_pkg::ADCS_OFS_WINDOW_HIGH_THRESHOLD + 5'h01, 8'h02, "window_high_threshold_hi");
      wr(adcs_pkg::ADCS_OFS_CTRL, 8'h01);
      wr(adcs_pkg::ADCS_OFS_CLKDIV, 8'h01);
      wr(adcs_pkg::ADCS_OFS_IRQEN, 8'h01);
      wr(adcs_pkg::ADCS_OFS_SAMPLE_LENGTH, 8'h00);
      wr(adcs_pkg::ADCS_OFS_INSEL, 8'h03);
      wr(adcs_pkg::ADCS_OFS_EVENT_INPUT_CTRL, 8'h00);
      wr(adcs_pkg::ADCS_OFS_DBG, 8'h00);
      wr(adcs_pkg::ADCS_OFS_WINMODE, 8'h00);
      convert(10'h155, 1'b0, 5'h03, 5'h03);
      d0 = samp_len;
      rd(adcs_pkg::ADCS_OFS_IRQFLAG, 8'h01, "flags_set");
      wr(adcs_pkg::ADCS_OFS_IRQFLAG, 8'h00);
      rd(adcs_pkg::ADCS_OFS_IRQFLAG, 8'h01, "flags_w0");
      wr(adcs_pkg::ADCS_OFS_IRQEN, 8'h02);
      @(posedge i_clk_sys);
      check("irq_masked", {15'h0000, o_irq}, 16'h0000);
      wr(adcs_pkg::ADCS_OFS_IRQFLAG, 8'h01);
      rd(adcs_pkg::ADCS_OFS_IRQFLAG, 8'h00, "flags_w1");
      wr(adcs_pkg::ADCS_OFS_IRQEN, 8'h01);
      rd(adcs_pkg::ADCS_OFS_RES, 8'h55, "res_kept");
      // a longer sample window, selector changed mid-run
      wr(adcs_pkg::ADCS_OFS_SAMPLE_LENGTH, 8'h03);
      convert(10'h2aa, 1'b0, 5'h03, 5'h05);
      check("samp_len", 16'(samp_len - d0), 16'h000c);
      rres(16'h02aa);
      wr(adcs_pkg::ADCS_OFS_SAMPLE_LENGTH, 8'h00);
      wr(adcs_pkg::ADCS_OFS_CLKDIV, 8'h02);
      convert(10'h001, 1'b0, 5'h05, 5'h05);
      check("samp_base", 16'(samp_len - d0), 16'h0008);
      rres(16'h0001);
      duty(1'b1, 16'h0002);
      duty(1'b0, 16'h0004);
      wr(adcs_pkg::ADCS_OFS_CLKDIV, 8'h00);
      for (i = 0; i < 4; i++) begin
         seed = xs(seed);
         i_over_ref <= (i == 0 || i == 2);
         i_under_gnd <= (i == 1 || i == 2);
         wr(adcs_pkg::ADCS_OFS_INSEL, {3'h0, sc[i]});
         convert(seed[9:0], 1'b0, sm[i], sc[i]);
         rres(i == 3 ? {6'h00, seed[9:0]} : (i == 1 ? 16'h0000 : 16'h03ff));
      end
      i_over_ref <= 1'b0;
      i_under_gnd <= 1'b0;
      wr(adcs_pkg::ADCS_OFS_INSEL, 8'h05);
      wr(adcs_pkg::ADCS_OFS_IRQEN, 8'h03);
      for (m = 0; m < 5; m++) begin
         wr(adcs_pkg::ADCS_OFS_WINMODE, m[7:0]);
         for (k = 0; k < 5; k++) begin
            res = {6'h00, dv[k]};
            r = {6'h00, win(m[2:0], res, 16'h0100, 16'h0200), 1'b1};
            convert(dv[k], 1'b0, 5'h05, 5'h05);
            rd(adcs_pkg::ADCS_OFS_IRQFLAG, r, "flags_window");
            wr(adcs_pkg::ADCS_OFS_IRQFLAG, 8'h02);
            rd(adcs_pkg::ADCS_OFS_IRQFLAG, 8'h01, "window_w1");
            rres(res);
         end
      end
      // each sample stays under the threshold, only the sum crosses it
      wr(adcs_pkg::ADCS_OFS_WINMODE, 8'h02);
      wr(adcs_pkg::ADCS_OFS_ACCUM, 8'h02);
      convert(10'h0a0, 1'b0, 5'h05, 5'h05);
      rd(adcs_pkg::ADCS_OFS_IRQFLAG, 8'h03, "acc_window");
      rres(16'h0280);
      wr(adcs_pkg::ADCS_OFS_ACCUM, 8'h06);
      convert(10'h3ff, 1'b0, 5'h05, 5'h05);
      rres(16'hffc0);
      wr(adcs_pkg::ADCS_OFS_ACCUM, 8'h00);
      pulse();
      repeat (3) @(posedge i_clk_sys);
      check("event_off", {15'h0000, o_sampling}, 16'h0000);
      wr(adcs_pkg::ADCS_OFS_EVENT_INPUT_CTRL, 8'h01);
      convert(10'h0f0, 1'b1, 5'h05, 5'h05);
      rres(16'h00f0);
      i_debug_halt <= 1'b1;
      pulse();
      repeat (3) @(posedge i_clk_sys);
      check("halt_ignore", {15'h0000, o_sampling}, 16'h0000);
      wr(adcs_pkg::ADCS_OFS_DBG, 8'h01);
      convert(10'h00f, 1'b1, 5'h05, 5'h05);
      rres(16'h000f);
      i_debug_halt <= 1'b0;
      wr(adcs_pkg::ADCS_OFS_CTRL, 8'h03);
      wr(adcs_pkg::ADCS_OFS_CMD, 8'h01);
      wait_on(1'b0, 1'b1);
      wait_on(1'b0, 1'b0);
      wait_on(1'b1, 1'b1);
      wait_on(1'b0, 1'b1);
      check("restart", {15'h0000, o_sampling}, 16'h0001);
      wr(adcs_pkg::ADCS_OFS_CTRL, 8'h00);
      give_verdict();
   end
endmodule
